// file: aqch_cmd.sv
// ASCII query command handler: frame parser, command executor, replies
`timescale 1ns/1ns
module aqch_cmd
  import aqch_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            rstn_in,
  // Received characters
  input  wire logic [7:0]      rx_char_in,
  input  wire logic            rx_valid_in,
  input  wire logic            rx_error_in,
  output logic                 rx_ready_out,
  // Reply characters
  output logic [7:0]           tx_char_out,
  output logic                 tx_valid_out,
  input  wire logic            tx_ready_in,
  // Configuration and pins
  input  wire logic [7:0]      module_address_in,
  input  wire logic            setup_sw_config_in,
  input  wire logic [CH_W-1:0] di_pins_in,
  input  wire logic [CH_W-1:0] do_pins_in,
  output logic [CH_W-1:0]      edge_mask_out,
  // Register port
  input  wire logic [3:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic [7:0]           reg_rdata_out,
  output logic                 irq_out
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    aqch_state_type              state;
    logic                        tilde;
    logic                        drop;
    logic [7:0]                  addr;
    logic [7:0]                  cmd;
    logic [NAME_MAX-1:0][7:0]    arg;
    logic [3:0]                  argc;
    logic [CH_W-1:0]             edges;
    logic [NAME_MAX-1:0][7:0]    name;
    logic [3:0]                  name_len;
    logic [TX_MAX-1:0][7:0]      tx_buf;
    logic [4:0]                  tx_len;
    logic [4:0]                  tx_idx;
    logic                        tx_valid;
    logic [7:0]                  tx_char;
    logic                        rx_ready;
    logic                        sw_s1;
    logic                        sw_s2;
    logic                        clr;
    logic [EV_W-1:0]             status;
    logic [EV_W-1:0]             mask;
    logic [7:0]                  rdata;
    logic                        irq;
  } aqch_core_type;

  localparam aqch_core_type CORE_RST = '{
    state:    ST_IDLE,
    edges:    EDGE_RST,
    rx_ready: 1'b1,
    default:  '0
  };

  aqch_core_type   r;
  aqch_core_type   n;
  logic [EV_W-1:0] ev;
  logic [4:0]      len;
  logic            nak;
  logic            sil;
  logic            take;
  logic [4:0]      rxhv;
  logic [4:0]      ahv0;
  logic [4:0]      ahv1;
  logic            exec_ok;

  aqch_latch_if lif ();

  aqch_latch u_latch (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .di_pins_in (di_pins_in),
    .do_pins_in (do_pins_in),
    .lat        (lif)
  );

  assign take    = rx_valid_in && r.rx_ready;
  assign rxhv    = hex_val(rx_char_in);
  assign ahv0    = hex_val(r.arg[0]);
  assign ahv1    = hex_val(r.arg[1]);
  assign exec_ok = (r.state == ST_EXEC) && !r.drop && !r.tilde;
  assign lif.clr = r.clr;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    n     = r;
    ev    = '0;
    len   = HDR_LEN;
    nak   = 1'b0;
    sil   = 1'b0;
    n.clr = 1'b0;
    n.sw_s1 = setup_sw_config_in;
    n.sw_s2 = r.sw_s1;
    if (r.tx_valid && tx_ready_in) begin
      n.tx_valid = 1'b0;
    end

    // Register port; reads answer in the next cycle only
    n.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_STATUS: n.rdata = {{(8-EV_W){1'b0}}, r.status};
        REG_MASK:   n.rdata = {{(8-EV_W){1'b0}}, r.mask};
        REG_EDGE:   n.rdata = r.edges;
        default:    n.rdata = '0;
      endcase
    end
    if (reg_wr_in && reg_addr_in == REG_MASK) begin
      n.mask = reg_wdata_in[EV_W-1:0];
    end

    // Receive: a delimiter restarts the frame from any state but ST_EXEC and ST_SEND
    if (take) begin
      if (rx_char_in == CH_DOLLAR || rx_char_in == CH_TILDE) begin
        n.state = ST_AHI;
        n.tilde = (rx_char_in == CH_TILDE);
        n.drop  = 1'b0;
        n.argc  = ARGC_NONE;
      end else begin
        case (r.state)
          ST_IDLE: begin
            n.state = ST_IDLE;
          end
          ST_AHI: begin
            if (rx_char_in == CH_CR) begin
              n.drop  = 1'b1;
              n.state = ST_EXEC;
            end else begin
              n.addr[7:4] = rxhv[3:0];
              n.drop      = r.drop | !rxhv[4];
              n.state     = ST_ALO;
            end
          end
          ST_ALO: begin
            if (rx_char_in == CH_CR) begin
              n.drop  = 1'b1;
              n.state = ST_EXEC;
            end else begin
              n.addr[3:0] = rxhv[3:0];
              // Foreign frames are swallowed up to their CR
              n.drop = r.drop | !rxhv[4] |
                ({r.addr[7:4], rxhv[3:0]} != module_address_in);
              n.state = ST_CMD;
            end
          end
          ST_CMD: begin
            if (rx_char_in == CH_CR) begin
              n.drop  = 1'b1;
              n.state = ST_EXEC;
            end else begin
              n.cmd   = rx_char_in;
              n.state = ST_ARG;
            end
          end
          ST_ARG: begin
            if (rx_char_in == CH_CR) begin
              n.state = ST_EXEC;
            end else if (r.argc < NAME_MAX[3:0]) begin
              n.arg[r.argc] = rx_char_in;
              n.argc        = r.argc + 4'h1;
            end else begin
              n.drop = 1'b1;
            end
          end
          default: begin
            n.state = r.state;
          end
        endcase
      end
    end
    if (rx_error_in && r.state != ST_IDLE && r.rx_ready) begin
      n.drop = 1'b1;
    end

    // Execute one complete frame
    if (r.state == ST_EXEC) begin
      n.state     = ST_IDLE;
      n.tx_buf    = '0;
      n.tx_buf[0] = CH_BANG;
      n.tx_buf[1] = hex_char(r.addr[7:4]);
      n.tx_buf[2] = hex_char(r.addr[3:0]);
      if (r.drop) begin
        sil = 1'b1;
      end else if (r.tilde) begin
        if (r.cmd == CH_O && r.argc != ARGC_NONE) begin
          n.name     = r.arg;
          n.name_len = r.argc;
          ev[EV_CFG] = 1'b1;
        end else begin
          nak = 1'b1;
        end
      end else begin
        case (r.cmd)
          CH_E: begin
            if (r.argc == ARGC_NONE) begin
              n.tx_buf[3] = hex_char(r.edges[7:4]);
              n.tx_buf[4] = hex_char(r.edges[3:0]);
              len = HDR_LEN + 5'h02;
            end else if (r.argc == ARGC_EDGE && ahv0[4] && ahv1[4]) begin
              n.edges    = {ahv0[3:0], ahv1[3:0]};
              ev[EV_CFG] = 1'b1;
            end else begin
              sil = 1'b1;
            end
          end
          CH_F: begin
            if (r.argc == ARGC_NONE) begin
              for (int i = 0; i < FW_LEN; i++) begin
                n.tx_buf[3+i] = FW_VERSION[31-8*i -: 8];
              end
              len = HDR_LEN + 5'(FW_LEN);
            end else begin
              sil = 1'b1;
            end
          end
          CH_I: begin
            if (r.argc == ARGC_NONE) begin
              n.tx_buf[3] = r.sw_s2 ? CH_ZERO : CH_ONE;
              len = HDR_LEN + 5'h01;
            end else begin
              sil = 1'b1;
            end
          end
          CH_L: begin
            if (r.argc != ARGC_SEL) begin
              sil = 1'b1;
            end else if (r.arg[0] == CH_ZERO || r.arg[0] == CH_ONE) begin
              // No address echo in this reply
              if (r.arg[0] == CH_ONE) begin
                n.tx_buf[1] = hex_char(lif.do_hi[7:4]);
                n.tx_buf[2] = hex_char(lif.do_hi[3:0]);
                n.tx_buf[3] = hex_char(lif.di_hi[7:4]);
                n.tx_buf[4] = hex_char(lif.di_hi[3:0]);
              end else begin
                n.tx_buf[1] = hex_char(lif.do_lo[7:4]);
                n.tx_buf[2] = hex_char(lif.do_lo[3:0]);
                n.tx_buf[3] = hex_char(lif.di_lo[7:4]);
                n.tx_buf[4] = hex_char(lif.di_lo[3:0]);
              end
              n.tx_buf[5] = CH_ZERO;
              n.tx_buf[6] = CH_ZERO;
              len = LATCH_LEN;
            end else begin
              nak = 1'b1;
            end
          end
          CH_C: begin
            if (r.argc == ARGC_NONE) begin
              n.clr = 1'b1;
            end else begin
              sil = 1'b1;
            end
          end
          CH_M: begin
            if (r.argc == ARGC_NONE) begin
              for (int i = 0; i < NAME_MAX; i++) begin
                if (i < int'(r.name_len)) begin
                  n.tx_buf[3+i] = r.name[i];
                end
              end
              len = HDR_LEN + {1'b0, r.name_len};
            end else begin
              sil = 1'b1;
            end
          end
          default: begin
            nak = 1'b1;
          end
        endcase
      end
      if (sil) begin
        ev[EV_DROP] = 1'b1;
      end else begin
        if (nak) begin
          n.tx_buf[0] = CH_QUEST;
          n.tx_buf[1] = hex_char(r.addr[7:4]);
          n.tx_buf[2] = hex_char(r.addr[3:0]);
          len = HDR_LEN;
          ev[EV_NAK] = 1'b1;
        end else begin
          ev[EV_ACK] = 1'b1;
        end
        n.tx_buf[len] = CH_CR;
        n.tx_len      = len + 5'h01;
        n.tx_idx      = '0;
        n.state       = ST_SEND;
      end
    end

    // Send: one character per accepted handshake
    if (r.state == ST_SEND && !n.tx_valid) begin
      if (r.tx_idx < r.tx_len) begin
        n.tx_char  = r.tx_buf[r.tx_idx];
        n.tx_valid = 1'b1;
        n.tx_idx   = r.tx_idx + 5'h01;
      end else begin
        n.state = ST_IDLE;
      end
    end

    // Events win over the read that clears them
    n.status = ((reg_rd_in && reg_addr_in == REG_STATUS) ?
                '0 : r.status) | ev;
    n.irq      = |(n.status & n.mask);
    n.rx_ready = (n.state != ST_EXEC) && (n.state != ST_SEND);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= CORE_RST;
    end else begin
      r <= n;
    end
  end

  assign rx_ready_out  = r.rx_ready;
  assign tx_char_out   = r.tx_char;
  assign tx_valid_out  = r.tx_valid;
  assign edge_mask_out = r.edges;
  assign reg_rdata_out = r.rdata;
  assign irq_out       = r.irq;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  a_drop_silent:
  assert property ((r.state == ST_EXEC && r.drop) |=>
    (r.state == ST_IDLE && !r.tx_valid) ##1
    (r.state != ST_SEND && !r.tx_valid) [*2])
    else $error("dropped frame produced a reply");

  a_reply_head:
  assert property ($rose(r.tx_valid) |->
    (r.tx_char == CH_BANG || r.tx_char == CH_QUEST))
    else $error("reply does not start with a delimiter");

  a_nak_addr:
  assert property ((r.state == ST_SEND && r.tx_buf[0] == CH_QUEST) |->
    (r.tx_buf[1] == hex_char(module_address_in[7:4]) &&
     r.tx_buf[2] == hex_char(module_address_in[3:0])))
    else $error("rejected reply lacks own address");

  a_addr_mismatch:
  assert property ((take && r.state == ST_ALO && rx_char_in != CH_CR &&
    rx_char_in != CH_DOLLAR && rx_char_in != CH_TILDE &&
    {r.addr[7:4], rxhv[3:0]} != module_address_in) |=>
    (r.drop && r.state == ST_CMD))
    else $error("foreign address not dropped");

  a_edge_set:
  assert property ((exec_ok && r.cmd == CH_E && r.argc == ARGC_EDGE &&
    ahv0[4] && ahv1[4]) |=>
    (edge_mask_out == {$past(ahv0[3:0]), $past(ahv1[3:0])} &&
     r.tx_len == 5'h04))
    else $error("edge mask not stored");

  a_edge_read:
  assert property ((exec_ok && r.cmd == CH_E && r.argc == ARGC_NONE) |=>
    (r.tx_buf[3] == hex_char(r.edges[7:4]) &&
     r.tx_buf[4] == hex_char(r.edges[3:0]) && r.tx_len == 5'h06))
    else $error("edge read reply wrong");

  a_sel_bad:
  assert property ((exec_ok && r.cmd == CH_L && r.argc == ARGC_SEL &&
    r.arg[0] != CH_ZERO && r.arg[0] != CH_ONE) |=>
    (r.tx_buf[0] == CH_QUEST && r.tx_len == 5'h04) ##1 tx_valid_out)
    else $error("bad selector not rejected");

  a_latch_fmt:
  assert property ((exec_ok && r.cmd == CH_L && r.argc == ARGC_SEL &&
    r.arg[0] == CH_ONE) |=>
    (r.tx_buf[0] == CH_BANG && r.tx_buf[5] == CH_ZERO &&
     r.tx_buf[6] == CH_ZERO && r.tx_len == 5'h08))
    else $error("latch reply layout wrong");

  a_clear_pulse:
  assert property ((exec_ok && r.cmd == CH_C && r.argc == ARGC_NONE) |=>
    (lif.clr && r.tx_len == 5'h04) ##1 !lif.clr)
    else $error("clear not issued once");

  a_name_store:
  assert property ((r.state == ST_EXEC && !r.drop && r.tilde &&
    r.cmd == CH_O && r.argc != ARGC_NONE) |=>
    (r.name_len == $past(r.argc) && r.name == $past(r.arg)))
    else $error("module name not stored");

  c_edge_set: cover property (exec_ok && r.cmd == CH_E &&
    r.argc == ARGC_EDGE);
  c_latch_read: cover property (exec_ok && r.cmd == CH_L &&
    r.argc == ARGC_SEL);
  c_name_set: cover property (r.state == ST_EXEC && r.tilde && !r.drop);
  c_drop: cover property (r.state == ST_EXEC && r.drop);

endmodule

// file: aqch_pkg.sv
// Constants, states and helpers of the ASCII query command handler
package aqch_pkg;

  // ************************************************************
  // Character codes
  // ************************************************************
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_TILDE  = 8'h7e;
  localparam logic [7:0] CH_CR     = 8'h0d;
  localparam logic [7:0] CH_BANG   = 8'h21;
  localparam logic [7:0] CH_QUEST  = 8'h3f;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_ONE    = 8'h31;
  localparam logic [7:0] CH_NINE   = 8'h39;
  localparam logic [7:0] CH_UA     = 8'h41;
  localparam logic [7:0] CH_UF     = 8'h46;
  localparam logic [7:0] CH_LA     = 8'h61;
  localparam logic [7:0] CH_LF     = 8'h66;
  localparam logic [7:0] CH_E      = 8'h45;
  localparam logic [7:0] CH_F      = 8'h46;
  localparam logic [7:0] CH_I      = 8'h49;
  localparam logic [7:0] CH_L      = 8'h4c;
  localparam logic [7:0] CH_C      = 8'h43;
  localparam logic [7:0] CH_M      = 8'h4d;
  localparam logic [7:0] CH_O      = 8'h4f;
  localparam logic [3:0] HEX_ALPHA = 4'h9;
  localparam logic [7:0] HEX_BASE  = 8'h37;

  // ************************************************************
  // Sizes, argument counts and reply lengths
  // ************************************************************
  localparam int         CH_W      = 8;
  localparam int         NAME_MAX  = 8;
  localparam int         TX_MAX    = 16;
  localparam logic [3:0] ARGC_NONE = 4'h0;
  localparam logic [3:0] ARGC_SEL  = 4'h1;
  localparam logic [3:0] ARGC_EDGE = 4'h2;
  localparam logic [4:0] HDR_LEN   = 5'h03;
  localparam logic [4:0] LATCH_LEN = 5'h07;
  localparam logic [7:0] EDGE_RST  = 8'h00;
  // Version string "V1.0": arbitrary value
  localparam logic [31:0] FW_VERSION = 32'h56312e30;
  localparam int          FW_LEN     = 4;

  // ************************************************************
  // Register port map and event bits
  // ************************************************************
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_MASK   = 4'h4;
  localparam logic [3:0] REG_EDGE   = 4'h8;
  localparam int         EV_W       = 4;
  localparam int         EV_ACK     = 0;
  localparam int         EV_NAK     = 1;
  localparam int         EV_DROP    = 2;
  localparam int         EV_CFG     = 3;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_AHI  = 7'b0000010,
    ST_ALO  = 7'b0000100,
    ST_CMD  = 7'b0001000,
    ST_ARG  = 7'b0010000,
    ST_EXEC = 7'b0100000,
    ST_SEND = 7'b1000000
  } aqch_state_type;

  // Bit 4 flags a legal hex digit, bits 3:0 carry its value
  function automatic logic [4:0] hex_val(input logic [7:0] c);
    logic [4:0] v;
    v = 5'h00;
    if (c >= CH_ZERO && c <= CH_NINE) begin
      v = {1'b1, c[3:0]};
    end else if ((c >= CH_UA && c <= CH_UF) ||
                 (c >= CH_LA && c <= CH_LF)) begin
      v = {1'b1, c[3:0] + HEX_ALPHA};
    end
    return v;
  endfunction

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    logic [7:0] c;
    c = (n <= HEX_ALPHA) ? {4'h3, n} : HEX_BASE + {4'h0, n};
    return c;
  endfunction

endpackage

// file: aqch_latch_if.sv
// Interface between the command core and the channel latch unit
`timescale 1ns/1ns
interface aqch_latch_if;
  logic       clr;
  logic [7:0] di_hi;
  logic [7:0] di_lo;
  logic [7:0] do_hi;
  logic [7:0] do_lo;
  modport ctrl (output clr, input di_hi, di_lo, do_hi, do_lo);
  modport unit (input clr, output di_hi, di_lo, do_hi, do_lo);
endinterface

// file: aqch_latch.sv
// Channel latch unit: sticky high and low flags for input and output pins
`timescale 1ns/1ns
module aqch_latch
  import aqch_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk_in,
  input  wire logic            rstn_in,
  // Channel pins
  input  wire logic [CH_W-1:0] di_pins_in,
  input  wire logic [CH_W-1:0] do_pins_in,
  // Flags toward the command core
  aqch_latch_if.unit           lat
);

  typedef struct packed {
    logic [CH_W-1:0] di_s1;
    logic [CH_W-1:0] di_s2;
    logic [CH_W-1:0] do_s1;
    logic [CH_W-1:0] do_s2;
    logic [CH_W-1:0] di_hi;
    logic [CH_W-1:0] di_lo;
    logic [CH_W-1:0] do_hi;
    logic [CH_W-1:0] do_lo;
    logic [1:0]      warm;
  } aqch_lat_type;

  aqch_lat_type    r;
  aqch_lat_type    n;
  logic [CH_W-1:0] live;

  // Flags follow the pins only once both stages hold real levels
  assign live = {CH_W{r.warm[1]}};

  always_comb begin
    n = r;
    n.di_s1 = di_pins_in;
    n.di_s2 = r.di_s1;
    n.do_s1 = do_pins_in;
    n.do_s2 = r.do_s1;
    // Stages hold reset zeros at first; those must not latch as lows
    n.warm  = {r.warm[0], 1'b1};
    // Set wins over clear: a level seen in the clear cycle stays latched
    n.di_hi = (lat.clr ? '0 : r.di_hi) | (r.di_s2 & live);
    n.di_lo = (lat.clr ? '0 : r.di_lo) | (~r.di_s2 & live);
    n.do_hi = (lat.clr ? '0 : r.do_hi) | (r.do_s2 & live);
    n.do_lo = (lat.clr ? '0 : r.do_lo) | (~r.do_s2 & live);
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lat.di_hi = r.di_hi;
  assign lat.di_lo = r.di_lo;
  assign lat.do_hi = r.do_hi;
  assign lat.do_lo = r.do_lo;

  a_clear_zeroes:
  assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    lat.clr |=> (r.di_hi == $past(r.di_s2) && r.do_lo == ~$past(r.do_s2)))
    else $error("latch flags survived a clear");

endmodule

// file: aqch_host.sv
// Host model: sends command frames and gathers the replies
`timescale 1ns/1ns
module aqch_host
  import aqch_pkg::*;
(
  // Clock
  input  wire logic       sys_clk_in,
  // Command characters
  output logic [7:0]      rx_char_out,
  output logic            rx_valid_out,
  output logic            rx_error_out,
  input  wire logic       rx_ready_in,
  // Reply characters
  input  wire logic [7:0] tx_char_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  string reply;
  bit    slow;
  initial begin
    rx_char_out  = 8'h00;
    rx_valid_out = 1'b0;
    rx_error_out = 1'b0;
    tx_ready_out = 1'b0;
    slow         = 1'b0;
  end
  // Held until the handler takes it; no drop between chars of a frame
  task automatic put(input logic [7:0] c);
    rx_char_out  <= c;
    rx_valid_out <= 1'b1;
    do @(posedge sys_clk_in); while (rx_ready_in !== 1'b1);
  endtask
  task automatic send(input string s, input bit err);
    @(posedge sys_clk_in);
    rx_error_out <= err;
    for (int i = 0; i < s.len(); i++) put(s[i]);
    put(CH_CR);
    rx_valid_out <= 1'b0;
    // Released line shows the inverse so a stale char is never reused
    rx_char_out  <= ~CH_CR;
    reply = "";
    // Slow mode stalls every other cycle to stretch the reply
    for (int n = 0; n < 60; n++) begin
      @(posedge sys_clk_in);
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
        if (tx_char_in === CH_CR) break;
        reply = {reply, string'(tx_char_in)};
      end
      tx_ready_out <= slow ? ~tx_ready_out : 1'b1;
    end
    tx_ready_out <= 1'b0;
    rx_error_out <= 1'b0;
  endtask
endmodule

// file: tb.sv
// Testbench of the ASCII query command handler
`timescale 1ns/1ns
module tb;
  import aqch_pkg::*;
  logic       sys_clk_in, rstn_in, rx_valid, rx_error, rx_ready;
  logic       tx_valid, tx_ready, sw_cfg, reg_wr_s, reg_rd_s, irq;
  logic [7:0] rx_char, tx_char, di_pins, do_pins, edge_mask;
  logic [7:0] reg_wdata, reg_rdata, own_addr;
  logic [3:0] reg_addr;
  int         miscompares, total_checks, cycles;
  aqch_cmd dut_u (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .rx_char_in(rx_char), .rx_valid_in(rx_valid), .rx_error_in(rx_error),
    .rx_ready_out(rx_ready), .tx_char_out(tx_char),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .module_address_in(own_addr), .setup_sw_config_in(sw_cfg),
    .di_pins_in(di_pins), .do_pins_in(do_pins), .edge_mask_out(edge_mask),
    .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr_s),
    .reg_rd_in(reg_rd_s), .reg_rdata_out(reg_rdata), .irq_out(irq));
  aqch_host host_u (.sys_clk_in(sys_clk_in), .rx_char_out(rx_char),
    .rx_valid_out(rx_valid), .rx_error_out(rx_error),
    .rx_ready_in(rx_ready), .tx_char_in(tx_char), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready));
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic note(input bit ok, input string msg);
    total_checks++;
    if (!ok) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic cmd(input string s, input bit err, input string exp);
    host_u.send(s, err);
    note(host_u.reply == exp, {s, " replied ", host_u.reply});
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_s  <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_s  <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    reg_addr <= a;
    reg_rd_s <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_s <= 1'b0;
    #1 note(reg_rdata === e, "register read");
  endtask
  // Hang guard, well above the length of the sequence
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up;
    end
  end
  initial begin
    rstn_in   = 1'b0;
    sw_cfg    = 1'b1;
    di_pins   = 8'hff;
    do_pins   = 8'hff;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr_s  = 1'b0;
    reg_rd_s  = 1'b0;
    own_addr  = 8'h01;
    repeat (6) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    note(tx_valid === 1'b0 && edge_mask === 8'h00, "reset values");
    reg_rd(REG_STATUS, 8'h00);
    reg_rd(REG_MASK, 8'h00);
    reg_wr(REG_MASK, 8'h04);
    reg_rd(REG_MASK, 8'h04);
    reg_rd(4'hc, 8'h00);
    cmd("$02E", 1'b0, "");
    note(irq === 1'b1, "drop interrupt");
    reg_rd(REG_STATUS, 8'h04);
    note(irq === 1'b0, "interrupt clear");
    cmd("$01E", 1'b0, "!0100");
    note(irq === 1'b0, "masked event");
    cmd("$01E3A", 1'b0, "!01");
    cmd("$01E", 1'b0, "!013A");
    note(edge_mask === 8'h3a, "edge mask pins");
    reg_wr(REG_EDGE, 8'hff);
    reg_rd(REG_EDGE, 8'h3a);
    cmd("$01E3", 1'b0, "");
    cmd("$01E55", 1'b1, "");
    host_u.slow = 1'b1;
    cmd("$01F", 1'b0, "!01V1.0");
    host_u.slow = 1'b0;
    cmd("$01I", 1'b0, "!010");
    sw_cfg <= 1'b0;
    cmd("$01I", 1'b0, "!011");
    cmd("$01L2", 1'b0, "?01");
    cmd("$01L0", 1'b0, "!000000");
    di_pins <= 8'h02;
    do_pins <= 8'h01;
    cmd("$01L1", 1'b0, "!FFFF00");
    cmd("$01C", 1'b0, "!01");
    cmd("$01L1", 1'b0, "!010200");
    cmd("$01L0", 1'b0, "!FEFD00");
    cmd("~01OPUMP42", 1'b0, "!01");
    cmd("$01M", 1'b0, "!01PUMP42");
    cmd("~01O123456789", 1'b0, "");
    cmd("$01M", 1'b0, "!01PUMP42");
    cmd("$01Z", 1'b0, "?01");
    cmd("~01P", 1'b0, "?01");
    cmd("$02", 1'b0, "");
    reg_rd(REG_STATUS, 8'h0f);
    note(irq === 1'b0, "interrupt after status read");
    // Mid-run reset: name, edge mask and mask register go back to defaults
    @(posedge sys_clk_in);
    rstn_in  <= 1'b0;
    own_addr <= 8'hb7;
    repeat (6) @(posedge sys_clk_in);
    rstn_in  <= 1'b1;
    note(edge_mask === 8'h00 && irq === 1'b0, "values after reset");
    reg_rd(REG_MASK, 8'h00);
    cmd("$B7M", 1'b0, "!B7");
    cmd("$b7E", 1'b0, "!B700");
    cmd("$01E", 1'b0, "");
    wrap_up;
  end
endmodule
